// file: design/lpc_regs.v
// Overview of operation
// - enable bit 7 of each control register switches its regulator on
// - bit 2 discharges the output while that regulator is off
// - bit 1 lets a regulator fault raise an interrupt; 0 blocks it
// - bit 0 reads live power-good; writes do nothing
// - six-bit voltage code in bits 5:0, upper two bits reserved
// - keep-alive control holds only the enable bit 7
// - press interrupt enable, bit 7, interrupts on button assertion
// - release interrupt enable, bit 6, interrupts on button release
// - source address byte defaults to FF and returns to FF after read, unless a new event arrives in the read cycle
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs_defs.vh"

module lpc_regs (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // regulator a
    output reg ldo_a_enable,
    output reg ldo_a_discharge,
    output reg ldo_a_fault_irq,
    input wire ldo_a_power_good,
    input wire ldo_a_fault,
    // regulator b
    output reg ldo_b_enable,
    output reg ldo_b_discharge,
    output reg ldo_b_fault_irq,
    output reg [5:0] ldo_b_voltage_code,
    input wire ldo_b_power_good,
    input wire ldo_b_fault,
    // regulator c
    output reg ldo_c_enable,
    output reg ldo_c_discharge,
    output reg ldo_c_fault_irq,
    output reg [5:0] ldo_c_voltage_code,
    input wire ldo_c_power_good,
    input wire ldo_c_fault,
    // keep-alive regulator
    output reg keepalive_ldo_enable,
    // push button, pin is low while pressed
    input wire push_button_input_n,
    output reg button_press_irq,
    output reg button_release_irq,
    // interrupt source byte and event pulse
    output reg [7:0] irq_source_address,
    output reg irq_event
);

    // stored control fields
    reg a_en;
    reg a_dis;
    reg a_flt_en;
    reg b_en;
    reg b_dis;
    reg b_flt_en;
    reg c_en;
    reg c_dis;
    reg c_flt_en;
    reg ka_en;
    reg [5:0] b_vcode;
    reg [5:0] c_vcode;
    reg button_press_irq_en;
    reg button_release_irq_en;

    // event detection state
    reg btn_prev_n;
    reg a_flt_prev;
    reg b_flt_prev;
    reg c_flt_prev;

    // decoded strobes and events
    wire wr_a_ctrl;
    wire wr_b_vsel;
    wire wr_b_ctrl;
    wire wr_c_vsel;
    wire wr_c_ctrl;
    wire wr_ka_ctrl;
    wire wr_btn_ctrl;
    wire rd_irq_addr;
    wire a_flt_gated;
    wire b_flt_gated;
    wire c_flt_gated;
    wire a_flt_evt;
    wire b_flt_evt;
    wire c_flt_evt;
    wire press_evt;
    wire release_evt;
    wire any_evt;
    reg [7:0] next_irq_source_address;
    reg [7:0] next_rdata;

    // full control byte: enable, discharge, fault enable, power good
    function [7:0] ctrl_byte;
        input en;
        input dis;
        input flt;
        input pg;
        begin
            ctrl_byte = 8'h00;
            ctrl_byte[`LPC_EN_BIT] = en;
            ctrl_byte[`LPC_DIS_BIT] = dis;
            ctrl_byte[`LPC_FLT_BIT] = flt;
            ctrl_byte[`LPC_PG_BIT] = pg;
        end
    endfunction

    // voltage byte with the top two bits held at zero
    function [7:0] vcode_byte;
        input [5:0] code;
        begin
            vcode_byte = {2'b00, code};
        end
    endfunction

    // write decode, one strobe per register
    assign wr_a_ctrl = reg_wr && (reg_addr == `LPC_LDO_A_CTRL_OFS);
    assign wr_b_vsel = reg_wr && (reg_addr == `LPC_LDO_B_VSEL_OFS);
    assign wr_b_ctrl = reg_wr && (reg_addr == `LPC_LDO_B_CTRL_OFS);
    assign wr_c_vsel = reg_wr && (reg_addr == `LPC_LDO_C_VSEL_OFS);
    assign wr_c_ctrl = reg_wr && (reg_addr == `LPC_LDO_C_CTRL_OFS);
    assign wr_ka_ctrl = reg_wr && (reg_addr == `LPC_KA_CTRL_OFS);
    assign wr_btn_ctrl = reg_wr && (reg_addr == `LPC_BTN_CTRL_OFS);
    assign rd_irq_addr = reg_rd && (reg_addr == `LPC_IRQ_ADDR_OFS);

    // fault interrupts only where software allowed them
    assign a_flt_gated = ldo_a_fault && a_flt_en;
    assign b_flt_gated = ldo_b_fault && b_flt_en;
    assign c_flt_gated = ldo_c_fault && c_flt_en;

    // rising edges only, so a stuck fault reports once
    assign a_flt_evt = a_flt_gated && !a_flt_prev;
    assign b_flt_evt = b_flt_gated && !b_flt_prev;
    assign c_flt_evt = c_flt_gated && !c_flt_prev;

    // button edges: press is the fall of the pin
    assign press_evt = button_press_irq_en && btn_prev_n &&
        !push_button_input_n;
    assign release_evt = button_release_irq_en && !btn_prev_n &&
        push_button_input_n;

    assign any_evt = a_flt_evt || b_flt_evt || c_flt_evt ||
        press_evt || release_evt;

    // control fields, reserved bits are never stored
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            a_en <= `LPC_CTRL_RST;
            a_dis <= `LPC_CTRL_RST;
            a_flt_en <= `LPC_CTRL_RST;
            b_en <= `LPC_CTRL_RST;
            b_dis <= `LPC_CTRL_RST;
            b_flt_en <= `LPC_CTRL_RST;
            c_en <= `LPC_CTRL_RST;
            c_dis <= `LPC_CTRL_RST;
            c_flt_en <= `LPC_CTRL_RST;
            ka_en <= `LPC_CTRL_RST;
            b_vcode <= `LPC_VCODE_RST;
            c_vcode <= `LPC_VCODE_RST;
            button_press_irq_en <= `LPC_CTRL_RST;
            button_release_irq_en <= `LPC_CTRL_RST;
        end
        else
        begin
            if (wr_a_ctrl)
            begin
                a_en <= reg_wdata[`LPC_EN_BIT];
                a_dis <= reg_wdata[`LPC_DIS_BIT];
                a_flt_en <= reg_wdata[`LPC_FLT_BIT];
            end
            if (wr_b_ctrl)
            begin
                b_en <= reg_wdata[`LPC_EN_BIT];
                b_dis <= reg_wdata[`LPC_DIS_BIT];
                b_flt_en <= reg_wdata[`LPC_FLT_BIT];
            end
            if (wr_c_ctrl)
            begin
                c_en <= reg_wdata[`LPC_EN_BIT];
                c_dis <= reg_wdata[`LPC_DIS_BIT];
                c_flt_en <= reg_wdata[`LPC_FLT_BIT];
            end
            // keep-alive takes only its enable
            if (wr_ka_ctrl)
                ka_en <= reg_wdata[`LPC_EN_BIT];
            if (wr_b_vsel)
                b_vcode <= reg_wdata[`LPC_VCODE_MSB:`LPC_VCODE_LSB];
            if (wr_c_vsel)
                c_vcode <= reg_wdata[`LPC_VCODE_MSB:`LPC_VCODE_LSB];
            // low watchdog bits live elsewhere and are dropped here
            if (wr_btn_ctrl)
            begin
                button_press_irq_en <= reg_wdata[`LPC_BTN_PRESS_BIT];
                button_release_irq_en <= reg_wdata[`LPC_BTN_REL_BIT];
            end
        end
    end

    // regulator drive; discharge only while the regulator is off
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            ldo_a_enable <= 1'b0;
            ldo_b_enable <= 1'b0;
            ldo_c_enable <= 1'b0;
            keepalive_ldo_enable <= 1'b0;
            ldo_a_discharge <= 1'b0;
            ldo_b_discharge <= 1'b0;
            ldo_c_discharge <= 1'b0;
            ldo_b_voltage_code <= `LPC_VCODE_RST;
            ldo_c_voltage_code <= `LPC_VCODE_RST;
        end
        else
        begin
            ldo_a_enable <= a_en;
            ldo_b_enable <= b_en;
            ldo_c_enable <= c_en;
            keepalive_ldo_enable <= ka_en;
            ldo_a_discharge <= a_dis && !a_en;
            ldo_b_discharge <= b_dis && !b_en;
            ldo_c_discharge <= c_dis && !c_en;
            ldo_b_voltage_code <= b_vcode;
            ldo_c_voltage_code <= c_vcode;
        end
    end

    // edge history and interrupt outputs
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            btn_prev_n <= 1'b1;
            a_flt_prev <= 1'b0;
            b_flt_prev <= 1'b0;
            c_flt_prev <= 1'b0;
            ldo_a_fault_irq <= 1'b0;
            ldo_b_fault_irq <= 1'b0;
            ldo_c_fault_irq <= 1'b0;
            button_press_irq <= 1'b0;
            button_release_irq <= 1'b0;
            irq_event <= 1'b0;
        end
        else
        begin
            btn_prev_n <= push_button_input_n;
            a_flt_prev <= a_flt_gated;
            b_flt_prev <= b_flt_gated;
            c_flt_prev <= c_flt_gated;
            ldo_a_fault_irq <= a_flt_evt;
            ldo_b_fault_irq <= b_flt_evt;
            ldo_c_fault_irq <= c_flt_evt;
            button_press_irq <= press_evt;
            button_release_irq <= release_evt;
            irq_event <= any_evt;
        end
    end

    // source address: a new event beats the read-back clear
    always @*
    begin
        next_irq_source_address = irq_source_address;
        if (rd_irq_addr)
            next_irq_source_address = `LPC_IRQ_ADDR_RST;
        if (press_evt || release_evt)
            next_irq_source_address = `LPC_BTN_CTRL_OFS;
        else if (a_flt_evt)
            next_irq_source_address = `LPC_LDO_A_CTRL_OFS;
        else if (b_flt_evt)
            next_irq_source_address = `LPC_LDO_B_CTRL_OFS;
        else if (c_flt_evt)
            next_irq_source_address = `LPC_LDO_C_CTRL_OFS;
    end

    always @(posedge sys_clk)
    begin
        if (rst)
            irq_source_address <= `LPC_IRQ_ADDR_RST;
        else
            irq_source_address <= next_irq_source_address;
    end

    // read mux; unmapped addresses read zero
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `LPC_LDO_A_CTRL_OFS:
                next_rdata = ctrl_byte(a_en, a_dis, a_flt_en,
                    ldo_a_power_good);
            `LPC_LDO_B_VSEL_OFS:
                next_rdata = vcode_byte(b_vcode);
            `LPC_LDO_B_CTRL_OFS:
                next_rdata = ctrl_byte(b_en, b_dis, b_flt_en,
                    ldo_b_power_good);
            `LPC_LDO_C_VSEL_OFS:
                next_rdata = vcode_byte(c_vcode);
            `LPC_LDO_C_CTRL_OFS:
                next_rdata = ctrl_byte(c_en, c_dis, c_flt_en,
                    ldo_c_power_good);
            `LPC_KA_CTRL_OFS:
                next_rdata = {ka_en, 7'h00};
            `LPC_BTN_CTRL_OFS:
                next_rdata = {button_press_irq_en,
                    button_release_irq_en, 6'h00};
            `LPC_IRQ_ADDR_OFS:
                next_rdata = irq_source_address;
            default:
                next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= `LPC_RDATA_RST;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= `LPC_RDATA_RST;
    end

endmodule // lpc_regs
`default_nettype wire

// file: design/lpc_regs_defs.vh
`ifndef LPC_REGS_DEFS_VH
`define LPC_REGS_DEFS_VH

// register offsets
`define LPC_LDO_A_CTRL_OFS 8'h81
`define LPC_LDO_B_VSEL_OFS 8'h90
`define LPC_LDO_B_CTRL_OFS 8'h91
`define LPC_LDO_C_VSEL_OFS 8'hA0
`define LPC_LDO_C_CTRL_OFS 8'hA1
`define LPC_KA_CTRL_OFS 8'hB1
`define LPC_BTN_CTRL_OFS 8'hC0
`define LPC_IRQ_ADDR_OFS 8'hC1

// control register field positions
`define LPC_EN_BIT 7
`define LPC_DIS_BIT 2
`define LPC_FLT_BIT 1
`define LPC_PG_BIT 0
`define LPC_VCODE_MSB 5
`define LPC_VCODE_LSB 0

// button control field positions
`define LPC_BTN_PRESS_BIT 7
`define LPC_BTN_REL_BIT 6

// reset values
`define LPC_CTRL_RST 1'b0
`define LPC_VCODE_RST 6'h00
`define LPC_IRQ_ADDR_RST 8'hFF
`define LPC_RDATA_RST 8'h00

`endif

// file: dv/lpc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lpc_regs_chk (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // regulator side
    input wire ldo_a_enable,
    input wire ldo_a_power_good,
    input wire ldo_a_fault,
    input wire ldo_a_fault_irq,
    input wire ldo_b_discharge,
    input wire [5:0] ldo_b_voltage_code,
    // button and interrupt source
    input wire push_button_input_n,
    input wire button_press_irq,
    input wire button_release_irq,
    input wire [7:0] irq_source_address,
    input wire irq_event
);
    // one clock domain, so clocking and reset are declared once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_enable_follows_write: assert property (
        reg_wr && reg_addr == 8'h81 |->
        ##2 ldo_a_enable == $past(reg_wdata[7], 2))
        else $error("enable output does not follow control write");
    chk_discharge_when_off: assert property (
        reg_wr && reg_addr == 8'h91 |-> ##2 ldo_b_discharge ==
        ($past(reg_wdata[2], 2) && !$past(reg_wdata[7], 2)))
        else $error("discharge output wrong after control write");
    chk_fault_pulse_once: assert property (
        ldo_a_fault_irq |-> $past(ldo_a_fault) ##1 !ldo_a_fault_irq)
        else $error("fault interrupt without fault or too long");
    chk_power_good_live: assert property (
        reg_rd && reg_addr == 8'h81 |=>
        reg_rdata[0] == $past(ldo_a_power_good))
        else $error("power good bit does not show the live input");
    chk_voltage_code_out: assert property (
        reg_wr && reg_addr == 8'h90 |->
        ##2 ldo_b_voltage_code == $past(reg_wdata[5:0], 2))
        else $error("voltage code output does not follow write");
    chk_keepalive_reserved: assert property (
        reg_rd && reg_addr == 8'hB1 |=> reg_rdata[6:0] == 7'h00)
        else $error("keep-alive reserved bits not zero");
    chk_press_on_fall: assert property (
        button_press_irq |-> irq_event && irq_source_address == 8'hC0
        && !$past(push_button_input_n) && $past(push_button_input_n, 2))
        else $error("press interrupt without a falling pin");
    chk_release_on_rise: assert property (
        button_release_irq |->
        $past(push_button_input_n) && !$past(push_button_input_n, 2))
        else $error("release interrupt without a rising pin");
    chk_source_read_clears: assert property (
        reg_rd && reg_addr == 8'hC1 |=> reg_rdata ==
        $past(irq_source_address) && (irq_event ||
        irq_source_address == 8'hFF))
        else $error("source address read or revert wrong");
    chk_button_reserved: assert property (
        reg_rd && reg_addr == 8'hC0 |=> reg_rdata[5:0] == 6'h00)
        else $error("button control reserved bits not zero");

    // main scenarios reached
    cover property (button_press_irq);
    cover property (button_release_irq);
    cover property (ldo_a_fault_irq);
    cover property (reg_rd && reg_addr == 8'hC1 ##1 reg_rdata != 8'hFF);
endmodule // lpc_regs_chk

bind lpc_regs lpc_regs_chk lpc_regs_chk_inst (.sys_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ldo_a_enable,
    .ldo_a_power_good, .ldo_a_fault, .ldo_a_fault_irq, .ldo_b_discharge,
    .ldo_b_voltage_code, .push_button_input_n, .button_press_irq,
    .button_release_irq, .irq_source_address, .irq_event);
`default_nettype wire

// file: dv/lpc_ldo_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpc_ldo_model (
    // clock
    input wire logic sys_clk,
    // control from the bank and fault request from the bench
    input wire logic enable,
    input wire logic fault_cmd,
    // status back to the bank
    output logic power_good = 1'b0,
    output logic fault = 1'b0
);
    // output good a cycle after turn-on; no soft-start ramp modelled
    always @(posedge sys_clk)
    begin
        power_good <= enable;
        fault <= fault_cmd;
    end
endmodule // lpc_ldo_model
`default_nettype wire

// file: dv/lpc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lpc_regs_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic push_button_input_n = 1'b1;
    logic [2:0] flt = 3'h0;
    integer n_fail = 0;
    integer n_tests = 0;
    wire [7:0] reg_rdata;
    wire [7:0] irq_source_address;
    wire [5:0] b_code;
    wire [5:0] c_code;
    wire [2:0] en;
    wire [2:0] dis;
    wire [2:0] firq;
    wire [2:0] pg;
    wire [2:0] fv;
    wire ka_en;
    wire press_irq;
    wire rel_irq;
    wire irq_event;

    // 200 MHz
    always #2.5 sys_clk = ~sys_clk;

    lpc_regs lpc_regs_inst (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ldo_a_enable(en[0]),
        .ldo_a_discharge(dis[0]), .ldo_a_fault_irq(firq[0]),
        .ldo_a_power_good(pg[0]), .ldo_a_fault(fv[0]), .ldo_b_enable(en[1]),
        .ldo_b_discharge(dis[1]), .ldo_b_fault_irq(firq[1]),
        .ldo_b_voltage_code(b_code), .ldo_b_power_good(pg[1]),
        .ldo_b_fault(fv[1]), .ldo_c_enable(en[2]), .ldo_c_discharge(dis[2]),
        .ldo_c_fault_irq(firq[2]), .ldo_c_voltage_code(c_code),
        .ldo_c_power_good(pg[2]), .ldo_c_fault(fv[2]),
        .keepalive_ldo_enable(ka_en),
        .push_button_input_n(push_button_input_n),
        .button_press_irq(press_irq), .button_release_irq(rel_irq),
        .irq_source_address(irq_source_address), .irq_event(irq_event));

    // one regulator model each for regulators a, b and c; keep-alive has none
    lpc_ldo_model lpc_ldo_model_inst [2:0] (.sys_clk(sys_clk), .enable(en),
        .fault_cmd(flt), .power_good(pg), .fault(fv));

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read", exp, reg_rdata);
    endtask

    task idle(input integer n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // bounded wait for an event pulse, then its source address
    task wait_evt(input logic [7:0] exp);
        integer i;
        i = 0;
        while (irq_event !== 1'b1 && i < 10)
        begin
            @(posedge sys_clk);
            #1;
            i = i + 1;
        end
        chk("event_seen", 8'h01, {7'h00, irq_event});
        chk("irq_addr", exp, irq_source_address);
        // a lost event ends the run rather than cascading
        if (irq_event !== 1'b1)
            print_verdict;
    endtask

    task no_evt;
        integer i;
        for (i = 0; i < 8; i = i + 1)
        begin
            idle(1);
            chk("no_event", 8'h00, {7'h00, irq_event});
        end
    endtask

    task print_verdict;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(8'hC1, 8'hFF);
        rd(8'h81, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h81, 8'hFF);
        idle(2);
        chk("a_en", 8'h01, {7'h00, en[0]});
        chk("a_dis", 8'h00, {7'h00, dis[0]});
        rd(8'h81, 8'h87);
        wr(8'h81, 8'h04);
        idle(2);
        chk("a_en", 8'h00, {7'h00, en[0]});
        chk("a_dis", 8'h01, {7'h00, dis[0]});
        rd(8'h81, 8'h04);
        wr(8'h90, 8'hFF);
        wr(8'hA0, 8'h2A);
        rd(8'h90, 8'h3F);
        rd(8'hA0, 8'h2A);
        chk("b_code", 8'h3F, {2'h0, b_code});
        chk("c_code", 8'h2A, {2'h0, c_code});
        wr(8'hB1, 8'hFF);
        rd(8'hB1, 8'h80);
        chk("ka_en", 8'h01, {7'h00, ka_en});
        wr(8'hC0, 8'hFF);
        rd(8'hC0, 8'hC0);
        // pin moves only on a rising edge
        @(posedge sys_clk);
        push_button_input_n <= 1'b0;
        wait_evt(8'hC0);
        chk("press_irq", 8'h01, {7'h00, press_irq});
        chk("rel_irq", 8'h00, {7'h00, rel_irq});
        rd(8'hC1, 8'hC0);
        rd(8'hC1, 8'hFF);
        @(posedge sys_clk);
        push_button_input_n <= 1'b1;
        wait_evt(8'hC0);
        chk("rel_irq", 8'h01, {7'h00, rel_irq});
        chk("press_irq", 8'h00, {7'h00, press_irq});
        wr(8'hC0, 8'h40);
        push_button_input_n <= 1'b0;
        no_evt;
        @(posedge sys_clk);
        push_button_input_n <= 1'b1;
        wait_evt(8'hC0);
        chk("rel_irq", 8'h01, {7'h00, rel_irq});
        rd(8'hC1, 8'hC0);
        wr(8'h81, 8'h02);
        flt[0] <= 1'b1;
        wait_evt(8'h81);
        chk("a_firq", 8'h01, {7'h00, firq[0]});
        wr(8'h91, 8'h85);
        flt[1] <= 1'b1;
        no_evt;
        chk("b_firq", 8'h00, {7'h00, firq[1]});
        chk("b_dis", 8'h00, {7'h00, dis[1]});
        wr(8'hA1, 8'h86);
        flt[2] <= 1'b1;
        wait_evt(8'hA1);
        chk("c_firq", 8'h01, {7'h00, firq[2]});
        rd(8'hA1, 8'h87);
        chk("c_dis", 8'h00, {7'h00, dis[2]});
        chk("c_en", 8'h01, {7'h00, en[2]});
        flt <= 3'h0;
        idle(3);
        print_verdict;
    end
endmodule // lpc_regs_bench
`default_nettype wire
